// ---- flash_cyc_if.sv ----
`timescale 1ns/1ns
interface flash_cyc_if #(
  parameter int AW = 19
);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          done;
  logic [7:0]    rdata;

  modport ctrl   (output req, wr, addr, wdata, input done, rdata);
  modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface

// ---- flash_cycle.sv ----
`timescale 1ns/1ns
`include "flash_regs.svh"
module flash_cycle import flash_pkg::*; #(
  parameter int AW = 19
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  flash_cyc_if.engine        cyc,
  output logic [AW-1:0]      fl_addr,
  output logic               fl_ce_n,
  output logic               fl_oe_n,
  output logic               fl_we_n,
  output logic [7:0]         fl_dq_out,
  output logic               fl_dq_oe_n,
  input  wire logic [7:0]    fl_dq_in
);

  typedef struct packed {
    cyc_state_e    st;
    logic [7:0]    cnt;
    logic          wr;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic          dq_oe_n;
    logic [7:0]    rdata;
    logic          done;
  } eng_s;

  eng_s q_r;
  eng_s q_nxt;

  // ----------------------------------------------------------------------
  // one bus cycle per request
  // ----------------------------------------------------------------------
  always_comb begin
    q_nxt      = q_r;
    q_nxt.done = 1'b0;
    unique case (q_r.st)
      CYC_IDLE: begin
        if (cyc.req) begin
          q_nxt.st      = CYC_SETUP;
          q_nxt.wr      = cyc.wr;
          q_nxt.addr    = cyc.addr;
          q_nxt.wdata   = cyc.wdata;
          q_nxt.ce_n    = 1'b0;
          q_nxt.oe_n    = cyc.wr;
          q_nxt.dq_oe_n = ~cyc.wr;
        end
      end
      // address settles before the strobe falls, so the later falling edge
      // latches a stable value
      CYC_SETUP: begin
        if (q_r.wr) begin
          q_nxt.we_n = 1'b0;
          q_nxt.cnt  = `FL_WE_CYC - 8'h01;
          q_nxt.st   = CYC_PULSE;
        end else begin
          q_nxt.cnt = `FL_RC_CYC - 8'h01;
          q_nxt.st  = CYC_READ;
        end
      end
      CYC_PULSE: begin
        if (q_r.cnt == 8'h00) begin
          q_nxt.we_n = 1'b1;
          q_nxt.st   = CYC_HOLD;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      CYC_HOLD: begin
        q_nxt.ce_n    = 1'b1;
        q_nxt.dq_oe_n = 1'b1;
        q_nxt.done    = 1'b1;
        q_nxt.st      = CYC_GAP;
      end
      CYC_READ: begin
        if (q_r.cnt == 8'h00) begin
          q_nxt.rdata = fl_dq_in;
          q_nxt.oe_n  = 1'b1;
          q_nxt.ce_n  = 1'b1;
          q_nxt.done  = 1'b1;
          q_nxt.st    = CYC_GAP;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      CYC_GAP: q_nxt.st = CYC_IDLE;
    endcase
  end

  // strobes idle high, bus released
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q_r         <= '0;
      q_r.ce_n    <= 1'b1;
      q_r.oe_n    <= 1'b1;
      q_r.we_n    <= 1'b1;
      q_r.dq_oe_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign fl_addr    = q_r.addr;
  assign fl_ce_n    = q_r.ce_n;
  assign fl_oe_n    = q_r.oe_n;
  assign fl_we_n    = q_r.we_n;
  assign fl_dq_out  = q_r.wdata;
  assign fl_dq_oe_n = q_r.dq_oe_n;
  assign cyc.done   = q_r.done;
  assign cyc.rdata  = q_r.rdata;

  // ----------------------------------------------------------------------
  // pin checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_read_no_drive: assert property (!fl_dq_oe_n |-> fl_oe_n && !fl_ce_n)
    else $error("data bus driven while output enable low or deselected");
  chk_write_strobes: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n)
    else $error("write strobe low while output enable low or deselected");
  chk_we_width: assert property ($fell(fl_we_n) |-> (!fl_we_n) [*2])
    else $error("write pulse too short");
  chk_addr_hold: assert property (!fl_ce_n && $past(!fl_ce_n) |-> $stable(fl_addr))
    else $error("address moved during a bus cycle");
  chk_data_hold: assert property ($rose(fl_we_n) |-> !fl_dq_oe_n && $stable(fl_dq_out))
    else $error("write data not held at strobe rise");

endmodule // flash_cycle

// ---- flash_dev_model.sv ----
`timescale 1ns/1ns
module flash_dev_model #(
  parameter int         AW         = 19,
  parameter logic [7:0] MAKER_CODE = 8'h3A, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h4C  // arbitrary value
) (
  input  wire logic [AW-1:0] fl_addr,
  input  wire logic          fl_ce_n,
  input  wire logic          fl_oe_n,
  input  wire logic          fl_we_n,
  input  wire logic [7:0]    dq_in,
  input  wire logic [15:0]   busy_len,
  output logic [7:0]         dev_dq,
  output logic               dev_oe_n
);
  logic [7:0]    mem [0:(1<<AW)-1];
  logic [7:0]    rd;
  logic [7:0]    last_r;
  logic [7:0]    pdata_r;
  logic [AW-1:0] addr_r;
  logic [2:0]    step_r;
  logic [15:0]   left_r;
  logic          busy_r, prog_r, tog_r, idm_r;
  realtime       t_fall;

  // erased array, read mode, no operation running
  initial begin
    for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hFF;
    {step_r, busy_r, prog_r, tog_r, idm_r, last_r} = '0;
    t_fall = 0;
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  task automatic do_write(input logic [AW-1:0] a, input logic [7:0] d);
    logic [14:0] c;
    c = a[14:0];
    if (busy_r) return;
    if (step_r == 3'd0 && d == 8'hF0) begin
      idm_r = 1'b0;
      return;
    end
    // unlock steps, any wrong write aborts to read
    case (step_r)
      3'd0: step_r = (c == 15'h5555 && d == 8'hAA) ? 3'd1 : 3'd0;
      3'd1: step_r = (c == 15'h2AAA && d == 8'h55) ? 3'd2 : 3'd0;
      3'd2: begin
        step_r = (c != 15'h5555) ? 3'd0 : (d == 8'hA0) ? 3'd3 : (d == 8'h80) ? 3'd4 : 3'd0;
        if (c == 15'h5555 && (d == 8'h90 || d == 8'hF0)) idm_r = (d == 8'h90);
      end
      3'd3: begin
        mem[a] = mem[a] & d;
        pdata_r = d;
        prog_r = 1'b1;
        busy_r = 1'b1;
        left_r = busy_len;
        step_r = 3'd0;
      end
      3'd4: step_r = (c == 15'h5555 && d == 8'hAA) ? 3'd5 : 3'd0;
      3'd5: step_r = (c == 15'h2AAA && d == 8'h55) ? 3'd6 : 3'd0;
      default: begin
        step_r = 3'd0;
        prog_r = 1'b0;
        left_r = busy_len;
        // sector picked by address bit 12 upward
        if (d == 8'h30) for (int i = 0; i < 4096; i++) mem[(int'(a) & ~4095) + i] = 8'hFF;
        if (d == 8'h10 && c == 15'h5555) for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hFF;
        busy_r = (d == 8'h30) || (d == 8'h10 && c == 15'h5555);
      end
    endcase
  endtask

  // ----------------------------------------------------------------
  // bus side
  // ----------------------------------------------------------------
  // address on falling, data on rising strobe; short pulses are noise
  always @(negedge fl_we_n) begin
    t_fall = $realtime;
    addr_r = fl_addr;
  end
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && fl_oe_n && ($realtime - t_fall) >= 5.0) do_write(addr_r, dq_in);
  end

  // bit six flips per finished read; busy ends after busy_len reads
  always @(posedge dev_oe_n) begin
    last_r = rd;
    if (busy_r) begin
      tog_r = ~tog_r;
      left_r = left_r - 16'd1;
      busy_r = (left_r != 16'd0);
    end
  end

  // status while busy, codes in identification mode
  always @* begin
    if (busy_r) rd = {prog_r ? ~pdata_r[7] : 1'b0, tog_r, 6'h00};
    else if (idm_r && fl_addr == '0) rd = MAKER_CODE;
    else if (idm_r && fl_addr == AW'(1)) rd = PART_CODE;
    else rd = mem[fl_addr];
  end

  // driven only with both enables low; released bus shows no stale value
  assign dev_oe_n = fl_ce_n | fl_oe_n;
  assign dev_dq   = dev_oe_n ? ~last_r : rd;
endmodule // flash_dev_model

// ---- flash_host.sv ----
// Functional notes
// - poll bit is only judged after the fourth or sixth write
// - alternating bit is only judged after the fourth or sixth write
// - program needs three unlock writes first; erase needs six writes
// - exit sequence returns the device to array reads
// - address latched on later falling strobe, data on earlier rising
// - sector erase: sixth write 30h at the sector address
// - chip erase: sixth write 10h at 5555h, array becomes all ones
// - exit is F0h to any address or the unlock prefix then F0h
`timescale 1ns/1ns
`include "flash_regs.svh"
module flash_host import flash_pkg::*; #(
  parameter int          AW         = 19,
  parameter int unsigned POLL_LIMIT = 100000
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          cmd_valid,
  input  flash_op_e          cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [7:0]    cmd_data,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic [7:0]         rsp_data,
  output logic               rsp_err,
  output logic               id_mode,
  output logic [AW-1:0]      fl_addr,
  output logic               fl_ce_n,
  output logic               fl_oe_n,
  output logic               fl_we_n,
  output logic [7:0]         fl_dq_out,
  output logic               fl_dq_oe_n,
  input  wire logic [7:0]    fl_dq_in
);

  typedef struct packed {
    host_state_e   st;
    flash_op_e     op;
    logic [AW-1:0] addr;
    logic [7:0]    data;
    logic [2:0]    step;
    logic          req;
    logic          wr;
    logic [AW-1:0] caddr;
    logic [7:0]    cwdata;
    logic          prev6;
    logic          prev_ok;
    logic [1:0]    confirm;
    logic [31:0]   polls;
    logic [7:0]    gap;
    logic          ready;
    logic          rsp_valid;
    logic [7:0]    rsp_data;
    logic          rsp_err;
    logic          id_mode;
  } host_s;

  host_s q_r;
  host_s q_nxt;

  flash_cyc_if #(.AW(AW)) cyc ();

  // ----------------------------------------------------------------------
  // command sequence tables
  // ----------------------------------------------------------------------
  function automatic logic [2:0] last_step(input flash_op_e op);
    unique case (op)
      OP_PROGRAM:       last_step = 3'd3;
      OP_SECTOR_ERASE,
      OP_CHIP_ERASE:    last_step = 3'd5;
      OP_ID_EXIT_SHORT: last_step = 3'd0;
      default:          last_step = 3'd2;
    endcase
  endfunction

  // address and byte of one write; step counts from zero
  function automatic logic [AW+7:0] seq_word(input flash_op_e op, input logic [2:0] step,
                                             input logic [AW-1:0] a, input logic [7:0] d);
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    u1 = AW'(`FL_UNLOCK1_ADDR);
    u2 = AW'(`FL_UNLOCK2_ADDR);
    unique case (step)
      3'd0: seq_word = (op == OP_ID_EXIT_SHORT) ? {a, `FL_D_ID_EXIT} : {u1, `FL_D_UNLOCK1};
      3'd1: seq_word = {u2, `FL_D_UNLOCK2};
      3'd2: begin
        unique case (op)
          OP_PROGRAM:      seq_word = {u1, `FL_D_PROGRAM};
          OP_SECTOR_ERASE,
          OP_CHIP_ERASE:   seq_word = {u1, `FL_D_ERASE};
          OP_ID_ENTRY:     seq_word = {u1, `FL_D_ID_ENTRY};
          default:         seq_word = {u1, `FL_D_ID_EXIT};
        endcase
      end
      3'd3: seq_word = (op == OP_PROGRAM) ? {a, d} : {u1, `FL_D_UNLOCK1};
      3'd4: seq_word = {u2, `FL_D_UNLOCK2};
      default: begin
        if (op == OP_SECTOR_ERASE) begin
          seq_word = {a[AW-1:`FL_SECTOR_LSB], {`FL_SECTOR_LSB{1'b0}}, `FL_D_SECTOR};
        end else begin
          seq_word = {u1, `FL_D_CHIP};
        end
      end
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  logic [AW+7:0] first_w;
  logic [AW+7:0] next_w;
  logic          exp7;
  logic          match7;
  logic          steady6;
  logic          is_wr_op;

  always_comb begin
    first_w  = seq_word(cmd_op, 3'd0, cmd_addr, cmd_data);
    next_w   = seq_word(q_r.op, q_r.step + 3'd1, q_r.addr, q_r.data);
    exp7     = (q_r.op == OP_PROGRAM) ? q_r.data[`FL_POLL_BIT] : 1'b1;
    match7   = cyc.rdata[`FL_POLL_BIT] == exp7;
    steady6  = q_r.prev_ok && (cyc.rdata[`FL_TOGGLE_BIT] == q_r.prev6);
    is_wr_op = (q_r.op == OP_PROGRAM) || (q_r.op == OP_SECTOR_ERASE)
               || (q_r.op == OP_CHIP_ERASE);

    q_nxt           = q_r;
    q_nxt.req       = 1'b0;
    q_nxt.rsp_valid = 1'b0;
    unique case (q_r.st)
      // new command only when nothing runs
      H_IDLE: begin
        if (cmd_valid && q_r.ready) begin
          q_nxt.ready   = 1'b0;
          q_nxt.op      = cmd_op;
          q_nxt.addr    = cmd_addr;
          q_nxt.data    = cmd_data;
          q_nxt.step    = 3'd0;
          q_nxt.req     = 1'b1;
          q_nxt.rsp_err = 1'b0;
          if (cmd_op == OP_READ) begin
            // id reads are plain reads at 0 or 1
            q_nxt.wr    = 1'b0;
            q_nxt.caddr = cmd_addr;
            q_nxt.st    = H_READ;
          end else begin
            // every write op opens with the table
            q_nxt.wr     = 1'b1;
            q_nxt.caddr  = first_w[AW+7:8];
            q_nxt.cwdata = first_w[7:0];
            q_nxt.st     = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (cyc.done) begin
          if (q_r.step != last_step(q_r.op)) begin
            q_nxt.step   = q_r.step + 3'd1;
            q_nxt.req    = 1'b1;
            q_nxt.caddr  = next_w[AW+7:8];
            q_nxt.cwdata = next_w[7:0];
          end else if (is_wr_op) begin
            // polling starts after last strobe rose
            q_nxt.st      = H_POLL;
            q_nxt.req     = 1'b1;
            q_nxt.wr      = 1'b0;
            q_nxt.prev_ok = 1'b0;
            q_nxt.confirm = 2'd0;
            q_nxt.polls   = 32'h0000_0000;
          end else begin
            // settle one read cycle before reuse
            q_nxt.st      = H_GAP;
            q_nxt.gap     = `FL_RC_CYC;
            q_nxt.id_mode = (q_r.op == OP_ID_ENTRY);
          end
        end
      end
      H_POLL: begin
        if (cyc.done) begin
          q_nxt.prev6   = cyc.rdata[`FL_TOGGLE_BIT];
          q_nxt.prev_ok = 1'b1;
          q_nxt.polls   = q_r.polls + 32'h0000_0001;
          q_nxt.req     = 1'b1;
          if (match7 && steady6) begin
            q_nxt.confirm = q_r.confirm + 2'd1;
          end else begin
            q_nxt.confirm = 2'd0;
          end
          if (match7 && steady6 && (q_r.confirm == 2'd2)) begin
            q_nxt.req       = 1'b0;
            q_nxt.rsp_valid = 1'b1;
            q_nxt.rsp_data  = cyc.rdata;
            q_nxt.ready     = 1'b1;
            q_nxt.st        = H_IDLE;
          end else if (q_r.polls == 32'(POLL_LIMIT)) begin
            q_nxt.req       = 1'b0;
            q_nxt.rsp_valid = 1'b1;
            q_nxt.rsp_err   = 1'b1;
            q_nxt.rsp_data  = cyc.rdata;
            q_nxt.ready     = 1'b1;
            q_nxt.st        = H_IDLE;
          end
        end
      end
      H_READ: begin
        if (cyc.done) begin
          q_nxt.rsp_valid = 1'b1;
          q_nxt.rsp_data  = cyc.rdata;
          q_nxt.ready     = 1'b1;
          q_nxt.st        = H_IDLE;
        end
      end
      H_GAP: begin
        if (q_r.gap == 8'h00) begin
          q_nxt.rsp_valid = 1'b1;
          q_nxt.ready     = 1'b1;
          q_nxt.st        = H_IDLE;
        end else begin
          q_nxt.gap = q_r.gap - 8'h01;
        end
      end
    endcase
  end

  // idle and ready after reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q_r       <= '0;
      q_r.ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cyc.req   = q_r.req;
  assign cyc.wr    = q_r.wr;
  assign cyc.addr  = q_r.caddr;
  assign cyc.wdata = q_r.cwdata;
  assign cmd_ready = q_r.ready;
  assign rsp_valid = q_r.rsp_valid;
  assign rsp_data  = q_r.rsp_data;
  assign rsp_err   = q_r.rsp_err;
  assign id_mode   = q_r.id_mode;

  flash_cycle #(.AW(AW)) u_cycle (
    .mclk       (mclk),
    .reset      (reset),
    .cyc        (cyc),
    .fl_addr    (fl_addr),
    .fl_ce_n    (fl_ce_n),
    .fl_oe_n    (fl_oe_n),
    .fl_we_n    (fl_we_n),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_dq_in   (fl_dq_in)
  );

  // ----------------------------------------------------------------------
  // sequence checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_unlock_prefix: assert property (q_r.req && q_r.wr && q_r.step == 3'd0
      && q_r.op != OP_ID_EXIT_SHORT |-> q_r.caddr == AW'(15'h5555) && q_r.cwdata == 8'hAA)
    else $error("write sequence does not open with the unlock prefix");
  chk_sector_addr: assert property (q_r.req && q_r.wr && q_r.step == 3'd5
      && q_r.op == OP_SECTOR_ERASE |-> q_r.caddr[11:0] == 12'h000 && q_r.cwdata == 8'h30)
    else $error("sector erase close is wrong");
  chk_chip_erase: assert property (q_r.req && q_r.wr && q_r.step == 3'd5
      && q_r.op == OP_CHIP_ERASE |-> q_r.caddr == AW'(15'h5555) && q_r.cwdata == 8'h10)
    else $error("chip erase close is wrong");
  chk_poll_late: assert property ($rose(q_r.st == H_POLL) |->
      q_r.step == ((q_r.op == OP_PROGRAM) ? 3'd3 : 3'd5) && $past(cyc.done))
    else $error("polling began before the last write");
  chk_done_confirm: assert property (q_r.rsp_valid && !q_r.rsp_err && $past(q_r.st) == H_POLL
      |-> $past(q_r.confirm) == 2'd2)
    else $error("completion reported without two confirming reads");
  chk_busy_refuse: assert property (q_r.st != H_IDLE |-> !q_r.ready)
    else $error("command port ready while an operation runs");
  chk_exit_mode: assert property (q_r.rsp_valid && (q_r.op == OP_ID_EXIT_SHORT
      || q_r.op == OP_ID_EXIT_LONG) |-> !q_r.id_mode)
    else $error("identification flag still set after exit");

endmodule // flash_host

// ---- flash_host_tb.sv ----
`timescale 1ns/1ns
module flash_host_tb import flash_pkg::*;;
  localparam int         AW    = 19;
  localparam logic [7:0] MAKER = 8'h3A; // arbitrary value
  localparam logic [7:0] PART  = 8'h4C; // arbitrary value
  logic          mclk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_err, id_mode;
  flash_op_e     cmd_op;
  logic [AW-1:0] cmd_addr, fl_addr;
  logic [7:0]    cmd_data, rsp_data, fl_dq_out, fl_dq_in, dev_dq;
  logic          fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n, dev_oe_n;
  logic [15:0]   busy_len;
  int            num_errors, n_tests;

  // the pin level: whoever enables its driver owns the bus
  assign fl_dq_in = !fl_dq_oe_n ? fl_dq_out : dev_dq;

  flash_host #(.AW(AW), .POLL_LIMIT(20)) DUT (
    .mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .id_mode(id_mode),
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in));

  flash_dev_model #(.AW(AW), .MAKER_CODE(MAKER), .PART_CODE(PART)) dev (
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .dq_in(fl_dq_in), .busy_len(busy_len), .dev_dq(dev_dq), .dev_oe_n(dev_oe_n));

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // called at a falling edge with the host idle; returns at the answer's falling edge
  task automatic run_cmd(input flash_op_e op, input logic [AW-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01);
  endtask

  // host and device never drive together
  always @(negedge mclk) if (!reset && fl_dq_oe_n === 1'b0) check({7'h00, dev_oe_n}, 8'h01);

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idle;
    check({4'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n}, 8'h0F);
    check({6'h00, cmd_ready, id_mode}, 8'h02);
  endtask

  // program with both polarities of the top bit, then read back
  task automatic t_program;
    logic [AW-1:0] a [2] = '{19'h01234, 19'h01235};
    logic [7:0]    d [2] = '{8'h3C, 8'hA5};
    for (int i = 0; i < 2; i++) begin
      run_cmd(OP_PROGRAM, a[i], d[i]);
      check(rsp_data, d[i]);
      check({7'h00, rsp_err}, 8'h00);
      run_cmd(OP_READ, a[i], 8'h00);
      check(rsp_data, d[i]);
    end
  endtask

  // sector erase spares other sectors; chip erase clears all
  task automatic t_erase;
    busy_len = 16'd6;
    run_cmd(OP_PROGRAM, 19'h02000, 8'h5A);
    run_cmd(OP_SECTOR_ERASE, 19'h01ABC, 8'h00);
    check(rsp_data, 8'hFF);
    run_cmd(OP_READ, 19'h01234, 8'h00);
    check(rsp_data, 8'hFF);
    run_cmd(OP_READ, 19'h02000, 8'h00);
    check(rsp_data, 8'h5A);
    run_cmd(OP_CHIP_ERASE, 19'h00000, 8'h00);
    check({7'h00, rsp_err}, 8'h00);
    run_cmd(OP_READ, 19'h02000, 8'h00);
    check(rsp_data, 8'hFF);
  endtask

  // codes in identification mode, both exit forms
  task automatic t_ident;
    flash_op_e ex [2] = '{OP_ID_EXIT_SHORT, OP_ID_EXIT_LONG};
    run_cmd(OP_PROGRAM, 19'h00000, 8'h12);
    for (int i = 0; i < 2; i++) begin
      run_cmd(OP_ID_ENTRY, 19'h00000, 8'h00);
      check({7'h00, id_mode}, 8'h01);
      run_cmd(OP_READ, 19'h00000, 8'h00);
      check(rsp_data, MAKER);
      run_cmd(OP_READ, 19'h00001, 8'h00);
      check(rsp_data, PART);
      run_cmd(ex[i], 19'h07F00, 8'h00);
      check({7'h00, id_mode}, 8'h00);
      run_cmd(OP_READ, 19'h00000, 8'h00);
      check(rsp_data, 8'h12);
    end
  endtask

  // a device that never finishes ends in the poll limit
  task automatic t_timeout;
    busy_len = 16'd1000;
    run_cmd(OP_PROGRAM, 19'h00100, 8'h00);
    check({7'h00, rsp_err}, 8'h01);
  endtask

  // command refused while busy, then a reset in mid-run
  task automatic t_refuse_reset;
    cmd_op = OP_PROGRAM;
    cmd_addr = 19'h00200;
    cmd_data = 8'h00;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_op = OP_ID_EXIT_SHORT;
    repeat (3) @(negedge mclk);
    check({7'h00, cmd_ready}, 8'h00);
    cmd_valid = 1'b0;
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    t_idle();
    @(negedge mclk);
    t_idle();
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // whole run is well under two thousand cycles; this limit of 20000 cycles is ample
  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    {cmd_valid, cmd_addr, cmd_data} = '0;
    cmd_op = OP_READ;
    reset = 1'b1;
    busy_len = 16'd5;
    num_errors = 0;
    n_tests = 0;
    repeat (8) @(negedge mclk);
    t_idle();
    reset = 1'b0;
    @(negedge mclk);
    t_idle();
    t_program();
    t_erase();
    t_ident();
    t_timeout();
    t_refuse_reset();
    tally_and_finish();
  end
endmodule // flash_host_tb

// ---- flash_pkg.sv ----
package flash_pkg;

  // host command set
  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_ID_ENTRY,
    OP_ID_EXIT_SHORT,
    OP_ID_EXIT_LONG
  } flash_op_e;

  // bus cycle engine states
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_SETUP,
    CYC_PULSE,
    CYC_HOLD,
    CYC_READ,
    CYC_GAP
  } cyc_state_e;

  // sequencer states
  typedef enum logic [2:0] {
    H_IDLE,
    H_WAIT,
    H_POLL,
    H_READ,
    H_GAP
  } host_state_e;

endpackage

// ---- flash_regs.svh ----
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// ----------------------------------------------------------------------
// command addresses and bytes
// ----------------------------------------------------------------------
`define FL_UNLOCK1_ADDR 15'h5555
`define FL_UNLOCK2_ADDR 15'h2AAA
`define FL_D_UNLOCK1    8'hAA
`define FL_D_UNLOCK2    8'h55
`define FL_D_PROGRAM    8'hA0
`define FL_D_ERASE      8'h80
`define FL_D_ID_ENTRY   8'h90
`define FL_D_ID_EXIT    8'hF0
`define FL_D_SECTOR     8'h30
`define FL_D_CHIP       8'h10
`define FL_SECTOR_LSB   12
`define FL_POLL_BIT     7
`define FL_TOGGLE_BIT   6

// ----------------------------------------------------------------------
// timing, in ns and in mclk cycles (least times round up)
// ----------------------------------------------------------------------
`define FL_CLK_NS       10
`define FL_RC_NS        70
`define FL_WE_NS        40
`define FL_GLITCH_NS    5
`define FL_RC_CYC       8'((`FL_RC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_WE_CYC       8'((`FL_WE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

`endif
